// ---- core/ofd_top.sv ----
// Overview of operation
// - A set force bit overrides the detector result on the pin, a clear one restores it.
// - While forced, the pin carries the force value bit regardless of magnitude.
// - The enable bit gates detection, resets to 0, and detection is off after reset.
// - The 13-bit upper threshold is low register plus bits 4:0 of its high register.
// - The 13-bit lower threshold is low register plus bits 4:0 of its high register.
// - An asserted pin drops after magnitude stays below lower for the 16-bit dwell count, or at once when the enable bit clears.
//
// Register access over APB was left to the implementer.
`default_nettype none
module ofd_top
   import ofd_pkg::*;
(
   // Clock and reset
   input wire logic CLK,
   input wire logic RESET,
   // APB slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [ADDR_W-1:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // Converter magnitude, same clock
   input wire logic [THR_W-1:0] MAGNITUDE,
   // Fast-detect pin and interrupt
   output logic OVERRANGE_FLAG_PIN_N,
   output logic IRQ
);
   logic [7:0] control_q;
   logic [7:0] upper_low_q;
   logic [7:0] upper_high_q;
   logic [7:0] lower_low_q;
   logic [7:0] lower_high_q;
   logic [7:0] dwell_low_q;
   logic [7:0] dwell_high_q;
   logic [ST_W-1:0] status_q;
   logic [ST_W-1:0] mask_q;
   logic [ST_W-1:0] events;
   logic [ST_W-1:0] clr_q;
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;
   logic irq_q;
   logic setup;
   logic done_wr;
   logic done_rd;
   logic [11:0] idx;
   logic [THR_W-1:0] upper;
   logic [THR_W-1:0] lower;
   logic assert_ev;
   logic release_ev;

   function automatic logic known(input logic [11:0] i);
      known = (i == IDX_CONTROL) || (i == IDX_UPPER_LOW) || (i == IDX_UPPER_HIGH) ||
         (i == IDX_LOWER_LOW) || (i == IDX_LOWER_HIGH) || (i == IDX_DWELL_LOW) ||
         (i == IDX_DWELL_HIGH) || (i == IDX_IRQ_STATUS) || (i == IDX_IRQ_MASK);
   endfunction

   assign idx = PADDR[ADDR_W-1:2];
   assign setup = PSEL && !PENABLE;
   // Completion edge: access phase seen with our ready high
   assign done_wr = PSEL && PENABLE && pready_q && PWRITE && known(idx);
   assign done_rd = PSEL && PENABLE && pready_q && !PWRITE;
   assign upper = {upper_high_q[4:0], upper_low_q};
   assign lower = {lower_high_q[4:0], lower_low_q};
   assign events = {release_ev, assert_ev};

   // No wait state: ready and read data are registered in setup
   always_ff @(posedge CLK) begin
      if (RESET) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= RDATA_RESET;
         clr_q <= '0;
      end else begin
         pready_q <= setup;
         if (setup) begin
            pslverr_q <= !known(idx);
            prdata_q <= RDATA_RESET;
            clr_q <= '0;
            if (!PWRITE) begin
               unique case (idx)
                  IDX_CONTROL: prdata_q[7:0] <= control_q;
                  IDX_UPPER_LOW: prdata_q[7:0] <= upper_low_q;
                  IDX_UPPER_HIGH: prdata_q[7:0] <= upper_high_q;
                  IDX_LOWER_LOW: prdata_q[7:0] <= lower_low_q;
                  IDX_LOWER_HIGH: prdata_q[7:0] <= lower_high_q;
                  IDX_DWELL_LOW: prdata_q[7:0] <= dwell_low_q;
                  IDX_DWELL_HIGH: prdata_q[7:0] <= dwell_high_q;
                  IDX_IRQ_STATUS: begin
                     prdata_q[ST_W-1:0] <= status_q;
                     clr_q <= status_q;
                  end
                  IDX_IRQ_MASK: prdata_q[ST_W-1:0] <= mask_q;
                  default: prdata_q <= RDATA_RESET;
               endcase
            end
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         control_q <= REG_RESET;
         upper_low_q <= REG_RESET;
         upper_high_q <= REG_RESET;
         lower_low_q <= REG_RESET;
         lower_high_q <= REG_RESET;
         dwell_low_q <= REG_RESET;
         dwell_high_q <= REG_RESET;
         mask_q <= '0;
      end else if (done_wr) begin
         unique case (idx)
            IDX_CONTROL: control_q <= PWDATA[7:0] & CTL_WMASK;
            IDX_UPPER_LOW: upper_low_q <= PWDATA[7:0];
            IDX_UPPER_HIGH: upper_high_q <= PWDATA[7:0] & THR_HIGH_WMASK;
            IDX_LOWER_LOW: lower_low_q <= PWDATA[7:0];
            IDX_LOWER_HIGH: lower_high_q <= PWDATA[7:0] & THR_HIGH_WMASK;
            IDX_DWELL_LOW: dwell_low_q <= PWDATA[7:0];
            IDX_DWELL_HIGH: dwell_high_q <= PWDATA[7:0];
            IDX_IRQ_MASK: mask_q <= PWDATA[ST_W-1:0];
            default: mask_q <= mask_q;
         endcase
      end
   end

   // Read clears only what was reported, so a new event is never lost
   always_ff @(posedge CLK) begin
      if (RESET) begin
         status_q <= '0;
      end else if (done_rd && (idx == IDX_IRQ_STATUS)) begin
         status_q <= (status_q & ~clr_q) | events;
      end else begin
         status_q <= status_q | events;
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(status_q & mask_q);
      end
   end

   ofd_detector #(
      .MAG_W(THR_W),
      .CNT_W(DWELL_W)
   ) u_det (
      .clk(CLK),
      .reset(RESET),
      .enable(control_q[CTL_ENABLE_BIT]),
      .force_on(control_q[CTL_FORCE_BIT]),
      .force_val(control_q[CTL_FORCE_VAL_BIT]),
      .upper(upper),
      .lower(lower),
      .dwell({dwell_high_q, dwell_low_q}),
      .magnitude(MAGNITUDE),
      .pin_q(OVERRANGE_FLAG_PIN_N),
      .assert_ev(assert_ev),
      .release_ev(release_ev)
   );

   assign PRDATA = prdata_q;
   assign PREADY = pready_q;
   assign PSLVERR = pslverr_q;
   assign IRQ = irq_q;
endmodule
`default_nettype wire

// ---- core/ofd_pkg.sv ----
`default_nettype none
package ofd_pkg;
   // Register indices; byte address is four times the index
   localparam logic [11:0] IDX_CONTROL = 12'h245;
   localparam logic [11:0] IDX_UPPER_LOW = 12'h247;
   localparam logic [11:0] IDX_UPPER_HIGH = 12'h248;
   localparam logic [11:0] IDX_LOWER_LOW = 12'h249;
   localparam logic [11:0] IDX_LOWER_HIGH = 12'h24A;
   localparam logic [11:0] IDX_DWELL_LOW = 12'h24B;
   localparam logic [11:0] IDX_DWELL_HIGH = 12'h24C;
   localparam logic [11:0] IDX_IRQ_STATUS = 12'h250;
   localparam logic [11:0] IDX_IRQ_MASK = 12'h251;
   localparam int ADDR_W = 14;
   // Control field positions
   localparam int CTL_ENABLE_BIT = 0;
   localparam int CTL_FORCE_VAL_BIT = 2;
   localparam int CTL_FORCE_BIT = 3;
   localparam logic [7:0] CTL_WMASK = 8'h0D;
   localparam logic [7:0] THR_HIGH_WMASK = 8'h1F;
   // Status field positions
   localparam int ST_ASSERT_BIT = 0;
   localparam int ST_RELEASE_BIT = 1;
   localparam int ST_W = 2;
   // Widths and reset values
   localparam int THR_W = 13;
   localparam int DWELL_W = 16;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
endpackage
`default_nettype wire

// ---- core/ofd_detector.sv ----
`default_nettype none
module ofd_detector
   import ofd_pkg::*;
#(
   parameter int MAG_W = 13,
   parameter int CNT_W = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Settings
   input wire logic enable,
   input wire logic force_on,
   input wire logic force_val,
   input wire logic [MAG_W-1:0] upper,
   input wire logic [MAG_W-1:0] lower,
   input wire logic [CNT_W-1:0] dwell,
   // Sample and result
   input wire logic [MAG_W-1:0] magnitude,
   output logic pin_q,
   output logic assert_ev,
   output logic release_ev
);
   logic flag_q;
   logic [CNT_W-1:0] cnt_q;
   logic above;
   logic below;
   logic done;

   assign above = magnitude > upper;
   assign below = magnitude < lower;
   assign done = below && (cnt_q >= dwell);
   assign assert_ev = enable && !flag_q && above;
   assign release_ev = enable && flag_q && !above && done;

   always_ff @(posedge clk) begin
      if (reset || !enable) begin
         flag_q <= 1'b0;
      end else if (above) begin
         flag_q <= 1'b1;
      end else if (flag_q && done) begin
         flag_q <= 1'b0;
      end
   end

   // Counter restarts whenever the magnitude leaves the low region
   always_ff @(posedge clk) begin
      if (reset || !flag_q || !below || above) begin
         cnt_q <= '0;
      end else if (cnt_q != '1) begin
         cnt_q <= cnt_q + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         pin_q <= 1'b0;
      end else if (force_on) begin
         pin_q <= force_val;
      end else begin
         pin_q <= enable && (above || (flag_q && !done));
      end
   end
endmodule
`default_nettype wire

// ---- verification/ofd_agc_model.sv ----
`default_nettype none
module ofd_agc_model (
   // Clock, reset, watched pin
   input wire logic clk,
   input wire logic reset,
   input wire logic flag_pin,
   // Episodes seen
   output logic [7:0] episodes_q
);
   timeunit 1ns;
   timeprecision 1ps;
   logic last_q;
   // Edges only: a held flag is one gain step
   always_ff @(posedge clk) begin
      if (reset) begin
         last_q <= 1'b0;
         episodes_q <= 8'h00;
      end else begin
         last_q <= flag_pin;
         if (flag_pin && !last_q) begin
            episodes_q <= episodes_q + 8'h01;
         end
      end
   end
endmodule
`default_nettype wire

// ---- verification/ofd_top_assertions.sv ----
`default_nettype none
module ofd_top_assertions
   import ofd_pkg::*;
(
   // Clock and reset
   input wire logic CLK,
   input wire logic RESET,
   // APB
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic PREADY,
   input wire logic PSLVERR,
   input wire logic [ADDR_W-1:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [31:0] PRDATA,
   // Detector side
   input wire logic OVERRANGE_FLAG_PIN_N,
   input wire logic IRQ,
   input wire logic [THR_W-1:0] MAGNITUDE
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] ctl_q;
   wire logic [11:0] idx = PADDR[13:2];
   wire logic setup = PSEL && !PENABLE;
   wire logic mapped = idx inside {[IDX_UPPER_LOW:IDX_DWELL_HIGH], IDX_CONTROL, IDX_IRQ_STATUS,
      IDX_IRQ_MASK};
   default clocking @(posedge CLK); endclocking
   default disable iff (RESET);
   always_ff @(posedge CLK) begin
      if (RESET) begin
         ctl_q <= 4'h0;
      end else if (PSEL && PENABLE && PREADY && PWRITE && idx == IDX_CONTROL) begin
         ctl_q <= PWDATA[3:0];
      end
   end
   a_setup_ready: assert property (setup |=> PREADY ##1 !PREADY) else $error("ready late");
   a_ready_cause: assert property ($rose(PREADY) |-> $past(setup)) else $error("stray ready");
   a_unmapped_error: assert property (setup && !mapped |=> PSLVERR && PRDATA == RDATA_RESET)
      else $error("unmapped not refused");
   a_mapped_ok: assert property (setup && mapped |=> !PSLVERR) else $error("mapped refused");
   a_force_level: assert property (
      ctl_q[3] |=> OVERRANGE_FLAG_PIN_N == $past(ctl_q[2])) else $error("force ignored");
   a_disabled_low: assert property (
      !ctl_q[0] && !ctl_q[3] |=> !OVERRANGE_FLAG_PIN_N) else $error("pin while off");
   a_rise_cause: assert property (
      $rose(OVERRANGE_FLAG_PIN_N) |-> $past(ctl_q[0] || ctl_q[3])) else $error("rise uncaused");
   a_reset_clears: assert property (@(posedge CLK) disable iff (1'b0)
      RESET |=> !OVERRANGE_FLAG_PIN_N && !IRQ && !PREADY) else $error("reset not clean");
   cover property (setup && !mapped);
   cover property ($rose(OVERRANGE_FLAG_PIN_N));
   cover property ($rose(IRQ));
endmodule
bind ofd_top ofd_top_assertions ofd_top_assertions_inst (.CLK(CLK), .RESET(RESET), .PSEL(PSEL),
   .PENABLE(PENABLE), .PWRITE(PWRITE), .PREADY(PREADY), .PSLVERR(PSLVERR), .PADDR(PADDR),
   .OVERRANGE_FLAG_PIN_N(OVERRANGE_FLAG_PIN_N), .IRQ(IRQ), .PWDATA(PWDATA), .PRDATA(PRDATA),
   .MAGNITUDE(MAGNITUDE));
`default_nettype wire

// ---- verification/adc_fast_threshold_detect_test.sv ----
`default_nettype none
module adc_fast_threshold_detect_test;
   import ofd_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic CLK = 1'b0, RESET = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
   logic [ADDR_W-1:0] PADDR = '0;
   logic [31:0] PWDATA = '0, PRDATA, rd;
   logic PREADY, PSLVERR, PIN, IRQ, err;
   logic [THR_W-1:0] MAG = '0;
   logic [7:0] episodes;
   logic [11:0] regs [9] = '{IDX_CONTROL, IDX_UPPER_LOW, IDX_UPPER_HIGH, IDX_LOWER_LOW,
      IDX_LOWER_HIGH, IDX_DWELL_LOW, IDX_DWELL_HIGH, IDX_IRQ_STATUS, IDX_IRQ_MASK};
   int bad_count = 0, cmp_count = 0, cycles = 0;
   always #10 CLK = ~CLK;
   ofd_top ofd_top_inst (.CLK(CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
      .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
      .PSLVERR(PSLVERR), .MAGNITUDE(MAG), .OVERRANGE_FLAG_PIN_N(PIN), .IRQ(IRQ));
   ofd_agc_model ofd_agc_model_inst (.clk(CLK), .reset(RESET), .flag_pin(PIN),
      .episodes_q(episodes));
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] idx, input logic [31:0] d);
      @(posedge CLK);
      PSEL <= 1'b1;
      PWRITE <= wr;
      PADDR <= {idx, 2'b00};
      PWDATA <= d;
      @(posedge CLK);
      PENABLE <= 1'b1;
      do @(posedge CLK); while (PREADY !== 1'b1);
      rd = PRDATA;
      err = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask
   task automatic rdchk(input string what, input logic [11:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, 32'h0);
      chk(what, exp, rd);
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge CLK);
      #1;
   endtask
   task automatic mag(input logic [THR_W-1:0] v);
      @(posedge CLK);
      MAG <= v;
   endtask
   always @(posedge CLK) begin
      cycles++;
      if (cycles == 3000) begin
         bad_count++;
         end_of_test();
      end
   end
   initial begin
      repeat (2) @(posedge CLK);
      RESET <= 1'b0;
      foreach (regs[i]) rdchk("reset", regs[i], 32'h0);
      apb(1'b1, IDX_CONTROL, 32'hFF);
      rdchk("control", IDX_CONTROL, 32'h0D);
      wt(2);
      chk("forced pin", 1'b1, PIN);
      apb(1'b1, IDX_CONTROL, 32'h0);
      wt(2);
      chk("off pin", 1'b0, PIN);
      apb(1'b1, IDX_UPPER_HIGH, 32'hFF);
      rdchk("upper high", IDX_UPPER_HIGH, 32'h1F);
      apb(1'b0, 12'h246, 32'h0);
      chk("slverr", 1'b1, err);
      chk("unmapped", 32'h0, rd);
      apb(1'b0, IDX_IRQ_STATUS, 32'h0);
      apb(1'b1, IDX_UPPER_LOW, 32'hA5);
      apb(1'b1, IDX_UPPER_HIGH, 32'h01);
      apb(1'b1, IDX_LOWER_LOW, 32'h23);
      apb(1'b1, IDX_LOWER_HIGH, 32'h01);
      apb(1'b1, IDX_DWELL_LOW, 32'h03);
      apb(1'b1, IDX_CONTROL, 32'h01);
      mag(13'h1A5);
      wt(3);
      chk("equal upper", 1'b0, PIN);
      mag(13'h1A6);
      wt(2);
      chk("over upper", 1'b1, PIN);
      mag(13'h123);
      wt(8);
      chk("at lower", 1'b1, PIN);
      mag(13'h122);
      wt(3);
      chk("dwell", 1'b1, PIN);
      wt(1);
      chk("released", 1'b0, PIN);
      chk("irq masked", 1'b0, IRQ);
      apb(1'b1, IDX_IRQ_MASK, 32'h03);
      wt(2);
      chk("irq", 1'b1, IRQ);
      rdchk("status", IDX_IRQ_STATUS, 32'h03);
      wt(2);
      chk("irq clear", 1'b0, IRQ);
      rdchk("status clear", IDX_IRQ_STATUS, 32'h0);
      apb(1'b1, IDX_CONTROL, 32'h0D);
      wt(2);
      chk("force high", 1'b1, PIN);
      mag(13'h1FFF);
      apb(1'b1, IDX_CONTROL, 32'h09);
      wt(2);
      chk("force low", 1'b0, PIN);
      apb(1'b1, IDX_CONTROL, 32'h01);
      wt(2);
      chk("unforced", 1'b1, PIN);
      apb(1'b1, IDX_CONTROL, 32'h0);
      wt(2);
      chk("disabled", 1'b0, PIN);
      chk("episodes", 32'h4, episodes);
      end_of_test();
   end
endmodule
`default_nettype wire
